/* boot_mode_defs.svh */
/*
 * Offsets, field positions, reset values and timing figures of the
 * reset-time mode selection block. Included by its bare name.
 */
`ifndef BOOT_MODE_DEFS_SVH
`define BOOT_MODE_DEFS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define OFS_PRIO        8'h00
`define OFS_STATUS      8'h04
`define OFS_LOADCNT     8'h08

// Fields of the priority and mode register.
`define PRIO_MDA        0
`define PRIO_SPECIAL_MODE_BIT       1
`define PRIO_BOOT_ROM_ENABLE      2

// Fields of the status register.
`define ST_MODE_LO      0
`define ST_SECURED      2
`define ST_SLOW         3
`define ST_STATE_LO     4
`define ST_VALID        7

// Reset values of the control bits before the mode pins are sampled.
`define RST_MDA         1'b0
`define RST_SPECIAL_MODE_BIT        1'b0
`define RST_BOOT_ROM_ENABLE       1'b0

// Boot ROM sits just below the C000 boundary of the vector page.
`define ROM_TOP         17'h0C000
`define ROM_BYTES       192

// First download characters and their meaning.
`define CHR_SYNC        8'hFF
`define CHR_MIS_A       8'hE0
`define CHR_MIS_B       8'hC0

// Timing: clock rate, baud rates, frame size and idle length in frames.
`define CLK_HZ          125000000
`define BAUD_FAST       7812
`define BAUD_SLOW       1200
`define BITS_PER_CHR    10
`define IDLE_CHRS       4
`define RAM_BYTES       512

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* boot_mode_pkg.sv */
/*
 * Types shared by the mode selection block: operating modes and the
 * states of the download sequencer. Assumes nothing of its users.
 */
`default_nettype none

package boot_mode_pkg;

    // Encoding is {special_mode_bit, mode_a_latch}.
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_EXPAND = 2'b01,
        MODE_BOOT   = 2'b10,
        MODE_TEST   = 2'b11
    } op_mode_t;

    typedef enum logic [2:0] {
        LD_OFF   = 3'b000,
        LD_ERASE = 3'b001,
        LD_BAUD  = 3'b010,
        LD_LOAD  = 3'b011,
        LD_JUMP  = 3'b100,
        LD_DONE  = 3'b101
    } ld_state_t;

endpackage

`default_nettype wire

/* boot_mode_select.sv */
/*
 * Reset-time mode selection, boot ROM mapping, vector redirection and a
 * hardware download sequencer, with an AXI4-Lite register slave.
 * Assumes the serial receiver, RAM, EEPROM eraser and CPU all run on
 * i_clk; mode pins and the security bit are asynchronous.
 */
// Behaviour
// RL1 - Mode-A latch takes the mode-A pin at release: 0 single, 1 expanded.
// RL2 - The special-mode bit takes the inverted mode-B pin at reset release.
// RL3 - Special bit and mode-A latch choose one of the four modes.
// RL4 - At reset the boot-ROM enable is 1 in bootstrap, else 0.
// RL5 - The 192-byte boot ROM appears in the map only while its enable is 1.
// RL6 - Boot-ROM enable is writable only in special modes; else 0, read-only.
// RL7 - Mode control bits are writable only while the special-mode bit is 1.
// RL8 - In special modes A14 is forced low on vector fetches, FFxx to BFxx.
// RL9 - In bootstrap the reset vector comes from the enabled boot ROM.
// RL10 - A secured part ignores the mode-A pin; mode-B picks single or boot.
// RL11 - The host sends FF first so the loader can pick one of two rates.
// RL12 - After the rate pick, bytes go to RAM, then control jumps to them.
// RL13 - A secured boot clears security only after EEPROM and RAM erase.
// RL14 - A first character of E0 or C0 switches the link to the slower rate.
// RL15 - The download ends after four idle character times.
// RL16 - Mode pins are sampled where internal reset ends, then held.
`default_nettype none
`include "boot_mode_defs.svh"

module boot_mode_select #(
    parameter int unsigned IDLE_FAST_CYC = int'((64'(`IDLE_CHRS) *
        `BITS_PER_CHR * `CLK_HZ + `BAUD_FAST - 1) / `BAUD_FAST),
    parameter int unsigned IDLE_SLOW_CYC = int'((64'(`IDLE_CHRS) *
        `BITS_PER_CHR * `CLK_HZ + `BAUD_SLOW - 1) / `BAUD_SLOW),
    parameter int unsigned RAM_BYTES     = `RAM_BYTES,
    parameter int unsigned ROM_BYTES     = `ROM_BYTES
) (
    input  wire logic        i_clk,              // System clock
    input  wire logic        i_nrst,             // Async reset, low
    input  wire logic [7:0]  s_axi_awaddr,       // Write address
    input  wire logic        s_axi_awvalid,      // Write address valid
    output logic             s_axi_awready,      // Write address ready
    input  wire logic [31:0] s_axi_wdata,        // Write data
    input  wire logic [3:0]  s_axi_wstrb,        // Byte strobes
    input  wire logic        s_axi_wvalid,       // Write data valid
    output logic             s_axi_wready,       // Write data ready
    output logic [1:0]       s_axi_bresp,        // Write response
    output logic             s_axi_bvalid,       // Response valid
    input  wire logic        s_axi_bready,       // Response ready
    input  wire logic [7:0]  s_axi_araddr,       // Read address
    input  wire logic        s_axi_arvalid,      // Read address valid
    output logic             s_axi_arready,      // Read address ready
    output logic [31:0]      s_axi_rdata,        // Read data
    output logic [1:0]       s_axi_rresp,        // Read response
    output logic             s_axi_rvalid,       // Read data valid
    input  wire logic        s_axi_rready,       // Read data ready
    input  wire logic        i_mode_a_pin,       // Mode A pin
    input  wire logic        i_mode_b_pin,       // Mode B pin
    input  wire logic        i_security_disable, // 0 = part secured
    input  wire logic [15:0] i_cpu_addr,         // CPU address
    input  wire logic        i_vector_fetch,     // Vector fetch cycle
    output logic [15:0]      o_mem_addr,         // Address to memory
    output logic             o_boot_rom_sel,     // Boot ROM selected
    output logic [7:0]       o_rom_index,        // Byte within ROM
    input  wire logic        i_rx_valid,         // Byte received
    input  wire logic [7:0]  i_rx_data,          // Received byte
    output logic             o_baud_slow,        // Slow rate chosen
    output logic             o_ram_we,           // RAM write pulse
    output logic [$clog2(RAM_BYTES)-1:0] o_ram_addr, // RAM address
    output logic [7:0]       o_ram_wdata,        // RAM write data
    output logic             o_jump,             // Jump pulse
    output logic             o_erase_req,        // Erase request
    input  wire logic        i_erase_done,       // Erase finished
    output logic             o_secured,          // Security active
    output boot_mode_pkg::op_mode_t o_mode,      // Operating mode
    output logic             o_mode_valid        // Mode sampled
);
    import boot_mode_pkg::*;

    localparam int CW = $clog2(RAM_BYTES + 1);

    if (RAM_BYTES == 0 || (RAM_BYTES & (RAM_BYTES - 1)) != 0 ||
        ROM_BYTES == 0 || ROM_BYTES > 256 || IDLE_FAST_CYC < 2 ||
        IDLE_SLOW_CYC < 2) begin : g_bad_params
        $error("boot_mode_select: unsupported parameter values");
    end

    function automatic logic rom_hit(input logic [15:0] a);
        rom_hit = (17'(a) >= 17'(`ROM_TOP - ROM_BYTES)) &&
                  (17'(a) < `ROM_TOP);
    endfunction

    // Two-flop synchronisers for the asynchronous straps.
    logic [2:0] sy1_q;
    logic [2:0] sy2_q;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sy1_q <= 3'h0;
            sy2_q <= 3'h0;
        end else begin
            sy1_q <= {i_security_disable, i_mode_b_pin, i_mode_a_pin};
            sy2_q <= sy1_q;
        end
    end
    logic a_s2;
    logic b_s2;
    logic security_disable_bit_s2;
    assign a_s2     = sy2_q[0];
    assign b_s2     = sy2_q[1];
    assign security_disable_bit_s2 = sy2_q[2];

    // Internal reset ends two edges after release, once the
    // synchronisers hold real pin levels rather than reset zeros.
    logic [1:0] rel_q;
    logic       sample;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rel_q <= 2'h0;
        end else if (rel_q != 2'h3) begin
            rel_q <= rel_q + 2'h1;
        end
    end
    assign sample = (rel_q == 2'h2);

    // AXI4-Lite write path: address and data may arrive in any order.
    logic       aw_hold_q;
    logic [7:0] aw_addr_q;
    logic       w_hold_q;
    logic [31:0] w_data_q;
    logic       w_be0_q;
    logic       bvalid_q;
    logic [1:0] bresp_q;
    logic       do_write;
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign do_write      = aw_hold_q && w_hold_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_hold_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_be0_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_be0_q  <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (aw_addr_q == `OFS_PRIO ||
                              aw_addr_q == `OFS_STATUS ||
                              aw_addr_q == `OFS_LOADCNT) ?
                             `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Mode control bits. Sampling wins over a software write that
    // lands on the same edge, so the strap is never lost.
    logic mda_q;
    logic special_mode_bit_q;
    logic boot_rom_enable_q;
    logic valid_q;
    logic prio_wr;
    logic mda_pick;
    assign prio_wr  = do_write && (aw_addr_q == `OFS_PRIO) && w_be0_q;
    assign mda_pick = security_disable_bit_s2 ? a_s2 : 1'b0; // see RL10
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mda_q   <= `RST_MDA;
            special_mode_bit_q  <= `RST_SPECIAL_MODE_BIT;
            boot_rom_enable_q <= `RST_BOOT_ROM_ENABLE;
            valid_q <= 1'b0;
        end else if (sample) begin // see RL16
            mda_q   <= mda_pick; // see RL1
            special_mode_bit_q  <= !b_s2; // see RL2
            boot_rom_enable_q <= !b_s2 && !mda_pick; // see RL4
            valid_q <= 1'b1;
        end else if (prio_wr && special_mode_bit_q) begin // see RL7
            mda_q   <= w_data_q[`PRIO_MDA];
            special_mode_bit_q  <= w_data_q[`PRIO_SPECIAL_MODE_BIT];
            boot_rom_enable_q <= w_data_q[`PRIO_BOOT_ROM_ENABLE] &&
                       w_data_q[`PRIO_SPECIAL_MODE_BIT]; // see RL6
        end else if (!special_mode_bit_q) begin
            boot_rom_enable_q <= 1'b0; // see RL6
        end
    end
    assign o_mode       = op_mode_t'({special_mode_bit_q, mda_q}); // see RL3
    assign o_mode_valid = valid_q;

    // Vector redirection and boot ROM decode on the CPU address path.
    always_comb begin
        o_mem_addr = i_cpu_addr;
        if (i_vector_fetch && special_mode_bit_q) begin
            o_mem_addr[14] = 1'b0; // see RL8
        end
    end
    assign o_boot_rom_sel = boot_rom_enable_q && rom_hit(o_mem_addr); // see RL5, RL9
    assign o_rom_index    = 8'(17'(o_mem_addr) -
                               17'(`ROM_TOP - ROM_BYTES));

    // Download sequencer. It only runs after a bootstrap reset; the
    // firmware equivalent would otherwise need a boot ROM image here.
    ld_state_t   st_q;
    logic        slow_q;
    logic        secured_q;
    logic [CW-1:0] cnt_q;
    logic [31:0] idle_q;
    logic [31:0] idle_lim;
    logic        ram_we_q;
    logic [7:0]  ram_wdata_q;
    logic [CW-1:0] ram_addr_q;
    assign idle_lim = slow_q ? IDLE_SLOW_CYC : IDLE_FAST_CYC;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q        <= LD_OFF;
            slow_q      <= 1'b0;
            secured_q   <= 1'b0;
            cnt_q       <= '0;
            idle_q      <= 32'h0000_0000;
            ram_we_q    <= 1'b0;
            ram_wdata_q <= 8'h00;
            ram_addr_q  <= '0;
        end else begin
            ram_we_q <= 1'b0;
            unique case (st_q)
                LD_OFF: begin
                    if (sample) begin
                        secured_q <= !security_disable_bit_s2;
                        if (!b_s2) begin
                            st_q <= security_disable_bit_s2 && a_s2 ? LD_DONE :
                                    (security_disable_bit_s2 ? LD_BAUD : LD_ERASE);
                        end else begin
                            st_q <= LD_DONE;
                        end
                    end
                end
                LD_ERASE: begin
                    if (i_erase_done) begin
                        secured_q <= 1'b0; // see RL13
                        st_q      <= LD_BAUD;
                    end
                end
                LD_BAUD: begin
                    if (i_rx_valid) begin
                        slow_q <= (i_rx_data == `CHR_MIS_A) ||
                                  (i_rx_data == `CHR_MIS_B); // see RL14
                        idle_q <= 32'h0000_0000;
                        st_q   <= LD_LOAD;
                    end
                end
                LD_LOAD: begin
                    if (i_rx_valid) begin
                        ram_we_q    <= 1'b1; // see RL12
                        ram_wdata_q <= i_rx_data;
                        ram_addr_q  <= cnt_q;
                        cnt_q       <= cnt_q + 1'b1;
                        idle_q      <= 32'h0000_0000;
                        if (cnt_q == CW'(RAM_BYTES - 1)) begin
                            st_q <= LD_JUMP;
                        end
                    end else if (idle_q == idle_lim - 32'h1) begin
                        st_q <= LD_JUMP; // see RL15
                    end else begin
                        idle_q <= idle_q + 32'h1;
                    end
                end
                LD_JUMP: begin
                    st_q <= LD_DONE; // see RL12
                end
                LD_DONE: begin
                    st_q <= LD_DONE;
                end
                default: begin
                    st_q <= LD_DONE;
                end
            endcase
        end
    end
    assign o_baud_slow = slow_q;
    assign o_ram_we    = ram_we_q;
    assign o_ram_wdata = ram_wdata_q;
    assign o_ram_addr  = ram_addr_q[$clog2(RAM_BYTES)-1:0];
    assign o_jump      = (st_q == LD_JUMP);
    assign o_erase_req = (st_q == LD_ERASE);
    assign o_secured   = secured_q;

    // AXI4-Lite read path.
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= `RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
            unique case (s_axi_araddr)
                `OFS_PRIO: begin
                    rdata_q[`PRIO_BOOT_ROM_ENABLE:0] <= {boot_rom_enable_q, special_mode_bit_q, mda_q};
                end
                `OFS_STATUS: begin
                    rdata_q[7:0] <= {valid_q, st_q, slow_q, secured_q,
                                     special_mode_bit_q, mda_q};
                end
                `OFS_LOADCNT: begin
                    rdata_q[CW-1:0] <= cnt_q;
                end
                default: begin
                    rresp_q <= `RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_mda_sample: assert property ( // see RL1
        sample |=> mda_q == ($past(security_disable_bit_s2) ? $past(a_s2) : 1'b0))
        else $error("mode-A latch not taken from pin");
    a_special_mode_bit_sample: assert property ( // see RL2
        sample |=> special_mode_bit_q == !$past(b_s2))
        else $error("special bit not inverse of mode-B pin");
    a_mode_out: assert property ( // see RL3
        sample && !b_s2 && !a_s2 |=> o_mode == MODE_BOOT)
        else $error("bootstrap straps did not give bootstrap mode");
    a_boot_rom_enable_reset: assert property ( // see RL4
        sample |=> boot_rom_enable_q == (o_mode == MODE_BOOT))
        else $error("boot ROM enable wrong after reset");
    a_rom_gated: assert property ( // see RL5
        o_boot_rom_sel |-> boot_rom_enable_q && o_rom_index < 8'(ROM_BYTES))
        else $error("boot ROM selected while disabled");
    a_boot_rom_enable_normal: assert property ( // see RL6
        valid_q && !special_mode_bit_q && !sample |=> !boot_rom_enable_q)
        else $error("boot ROM enable set in normal mode");
    a_wr_blocked: assert property ( // see RL7
        prio_wr && !special_mode_bit_q && !sample |=> $stable({mda_q, special_mode_bit_q}))
        else $error("mode bits written in normal mode");
    a_vec_a14: assert property ( // see RL8
        i_vector_fetch && special_mode_bit_q |-> !o_mem_addr[14])
        else $error("A14 not forced low on vector fetch");
    a_secure_a: assert property ( // see RL10
        sample && !security_disable_bit_s2 |=> !mda_q)
        else $error("secured part took mode-A pin");
    a_load_store: assert property ( // see RL12
        st_q == LD_LOAD && i_rx_valid
        |=> o_ram_we && o_ram_wdata == $past(i_rx_data))
        else $error("received byte not stored");
    a_erase_first: assert property ( // see RL13
        secured_q |-> st_q != LD_LOAD && st_q != LD_BAUD)
        else $error("download before erase on secured part");
    a_slow_pick: assert property ( // see RL14
        st_q == LD_BAUD && i_rx_valid && i_rx_data == `CHR_MIS_A
        |=> o_baud_slow ##0 st_q == LD_LOAD)
        else $error("mismatch character did not pick slow rate");
    a_idle_end: assert property ( // see RL15
        st_q == LD_LOAD && !i_rx_valid && idle_q == idle_lim - 32'h1
        |=> o_jump ##1 st_q == LD_DONE)
        else $error("idle timeout did not end download");
    a_bits_hold: assert property ( // see RL16
        rel_q == 2'h3 && !prio_wr && special_mode_bit_q |=> $stable({mda_q, special_mode_bit_q}))
        else $error("mode bits changed without a write");

    c_boot_slow: cover property (st_q == LD_BAUD && i_rx_valid &&
                                 i_rx_data == `CHR_MIS_B);
    c_jump: cover property (o_jump && cnt_q != '0);
    c_test_boot_rom_enable: cover property (o_mode == MODE_TEST && prio_wr &&
                                  w_data_q[`PRIO_BOOT_ROM_ENABLE]);

endmodule // boot_mode_select

`default_nettype wire

/* host_link.sv */
/*
 * Host end of the serial download: hands each character to the block as
 * a one-cycle strobe with its byte. Assumes the bench owns the clock.
 */
`default_nettype none

module host_link (
    output logic       o_valid, // Character strobe
    output logic [7:0] o_data,  // Character value
    input  wire logic  i_clk    // System clock
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_valid = 1'b0;
        o_data  = 8'h00;
    end

    // The bench sends a rate-pick character first: FF, E0 or C0.
    // Between characters the byte shows the inverse of the last one, so
    // a receiver that reads it outside the strobe sees a wrong value.
    // Falling silent is how a download is ended.
    task automatic send(input logic [7:0] b, input int gap);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_data  <= b;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_data  <= ~b;
        repeat (gap) @(posedge i_clk);
    endtask
endmodule // host_link

`default_nettype wire

/* boot_mode_select_bench.sv */
/*
 * Self-checking bench of the mode selection block: mode straps, vector
 * redirection, register locking, download and security. Assumes the
 * design is built with short idle counts of 20 and 40 cycles.
 */
`default_nettype none
`include "boot_mode_defs.svh"

module boot_mode_select_bench
    import boot_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_clk = 1'b0, i_nrst = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, i_vector_fetch = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        i_mode_a_pin = 1'b0, i_mode_b_pin = 1'b1;
    logic        i_security_disable = 1'b1, i_erase_done = 1'b0;
    logic [15:0] i_cpu_addr = 16'hFFFE, o_mem_addr;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, o_boot_rom_sel, o_baud_slow, o_ram_we;
    logic        o_jump, o_erase_req, o_secured, o_mode_valid, i_rx_valid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  o_rom_index, o_ram_wdata, i_rx_data;
    logic [8:0]  o_ram_addr;
    op_mode_t    o_mode;
    int          miscompares = 0, tests_run = 0, cyc = 0, nw = 0;
    logic [8:0]  wa [8];
    logic [7:0]  wd [8];

    boot_mode_select #(.IDLE_FAST_CYC(20), .IDLE_SLOW_CYC(40)) dut (
        .i_clk, .i_nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .i_mode_a_pin, .i_mode_b_pin,
        .i_security_disable, .i_cpu_addr, .i_vector_fetch, .o_mem_addr,
        .o_boot_rom_sel, .o_rom_index, .i_rx_valid, .i_rx_data,
        .o_baud_slow, .o_ram_we, .o_ram_addr, .o_ram_wdata, .o_jump,
        .o_erase_req, .i_erase_done, .o_secured, .o_mode, .o_mode_valid);
    host_link host (.o_valid(i_rx_valid), .o_data(i_rx_data), .i_clk);

    always #4 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            nw <= 0;
        end else if (o_ram_we === 1'b1 && nw < 8) begin
            wa[nw] <= o_ram_addr;
            wd[nw] <= o_ram_wdata;
            nw     <= nw + 1;
        end
        cyc <= cyc + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Holds reset for eight cycles, then lets the straps be sampled.
    task automatic boot(input logic a, input logic b, input logic s);
        @(posedge i_clk);
        i_nrst             <= 1'b0;
        i_mode_a_pin       <= a;
        i_mode_b_pin       <= b;
        i_security_disable <= s;
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (6) @(posedge i_clk);
    endtask

    // Ready is combinational, so handshakes are judged at the falling
    // edge, where inputs and ready already hold their rising-edge values.
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        logic aw, w, b;
        @(posedge i_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(negedge i_clk);
            aw = s_axi_awvalid & s_axi_awready;
            w  = s_axi_wvalid & s_axi_wready;
            b  = s_axi_bvalid;
            r  = s_axi_bresp;
            @(posedge i_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (b !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        logic ar, v;
        @(posedge i_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(negedge i_clk);
            ar = s_axi_arvalid & s_axi_arready;
            v  = s_axi_rvalid;
            d  = s_axi_rdata;
            r  = s_axi_rresp;
            @(posedge i_clk);
            if (ar) s_axi_arvalid <= 1'b0;
        end while (v !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    // Every mode-pin combination, its vector page and its register locking.
    task automatic test_modes;
        logic [31:0] d;
        logic [1:0]  r;
        for (int m = 0; m < 4; m++) begin
            boot(m[0], ~m[1], 1'b1);
            chk(o_mode, m);
            chk(o_mode_valid, 1);
            axr(`OFS_PRIO, d, r);
            chk(d, {(m == 2), m[1], m[0]});
            i_mode_a_pin   <= ~m[0];
            i_mode_b_pin   <= m[1];
            i_vector_fetch <= 1'b1;
            repeat (6) @(posedge i_clk);
            chk(o_mode, m);
            chk(o_mem_addr, m[1] ? 16'hBFFE : 16'hFFFE);
            chk(o_boot_rom_sel, (m == 2));
            if (m == 2) chk(o_rom_index, 8'hBE);
            i_vector_fetch <= 1'b0;
            @(posedge i_clk);
            @(negedge i_clk);
            chk(o_mem_addr, 16'hFFFE);
            @(posedge i_clk);
            i_cpu_addr <= 16'hBF3F;
            @(posedge i_clk);
            chk(o_boot_rom_sel, 0);
            i_cpu_addr <= 16'hFFFE;
            axw(`OFS_PRIO, 32'h7, r);
            axr(`OFS_PRIO, d, r);
            chk(d, m[1] ? 32'h7 : {(m == 2), m[1], m[0]});
        end
        axr(8'h40, d, r);
        chk(d, 32'h0);
        chk(r, `RESP_SLVERR);
        axw(8'h40, 32'h1, r);
        chk(r, `RESP_SLVERR);
    endtask

    // Download after a given first character, then the idle end.
    task automatic test_load(input logic [7:0] first, input logic slow,
                             input int min_idle);
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        boot(1'b0, 1'b0, 1'b1);
        host.send(first, 3);
        chk(o_baud_slow, slow);
        for (int k = 0; k < 3; k++) host.send(8'hA0 + k[7:0], 2);
        n = 0;
        while (o_jump !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        chk(o_jump, 1);
        chk(n > min_idle, 1);
        chk(nw, 3);
        for (int k = 0; k < 3; k++) begin
            chk({wa[k], wd[k]}, {k[8:0], 8'hA0 + k[7:0]});
        end
        axr(`OFS_LOADCNT, d, r);
        chk(d, 32'h3);
        axr(`OFS_STATUS, d, r);
        chk(d, {1'b1, LD_DONE, slow, 1'b0, MODE_BOOT});
    endtask

    // Secured part: mode-A ignored, erase before leaving the secure state.
    task automatic test_secure;
        boot(1'b1, 1'b1, 1'b0);
        chk(o_mode, MODE_SINGLE);
        boot(1'b1, 1'b0, 1'b0);
        chk(o_mode, MODE_BOOT);
        chk({o_secured, o_erase_req}, 2'b11);
        i_erase_done <= 1'b1;
        @(posedge i_clk);
        i_erase_done <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk({o_secured, o_erase_req}, 2'b00);
    endtask

    // A hang leaves the scenarios unfinished; the cycle ceiling then
    // counts as a mismatch and the run still ends in the one report.
    initial begin
        fork
            begin
                test_modes();
                test_load(8'hFF, 1'b0, 10);
                test_load(8'hE0, 1'b1, 30);
                test_load(8'hC0, 1'b1, 30);
                test_secure();
            end
            wait (cyc >= 20000);
        join_any
        if (cyc >= 20000) begin
            miscompares++;
        end
        end_of_test();
    end
endmodule // boot_mode_select_bench

`default_nettype wire
